// file: rtl/mcba_bank.sv
// One core memory bank with three prioritised ports and a port expander
`timescale 1ns/1ps
module mcba_bank
  import mcba_pkg::*;
#(
  parameter int MEM_K         = 16,
  parameter int ACCESS_CYCLES = 4
) (
  input  wire logic                           clk_sys,
  input  wire logic                           rst,
  input  wire logic [3:0]                     avs_address,
  input  wire logic                           avs_read,
  input  wire logic                           avs_write,
  input  wire logic [31:0]                    avs_writedata,
  input  wire logic [3:0]                     avs_byteenable,
  output logic      [31:0]                    avs_readdata,
  output logic                                avs_waitrequest,
  input  wire logic [NEXP-1:0]                exp_req,
  input  wire logic [NEXP-1:0][ADDR_W-1:0]    exp_addr,
  input  wire logic [NEXP-1:0]                exp_write,
  input  wire logic [NEXP-1:0][DATA_W-1:0]    exp_wdata,
  output logic      [NEXP-1:0]                exp_present,
  output logic      [NEXP-1:0]                exp_done,
  output logic      [DATA_W-1:0]              exp_rdata,
  output logic                                present_ack_first_port,
  output logic                                override_b_and_c_to_a,
  input  wire logic                           port_b_req,
  input  wire logic [ADDR_W-1:0]              port_b_addr,
  input  wire logic                           port_b_write,
  input  wire logic [DATA_W-1:0]              port_b_wdata,
  output logic                                present_ack_b,
  output logic                                port_b_done,
  output logic      [DATA_W-1:0]              port_b_rdata,
  output logic                                override_a_and_c,
  input  wire logic                           port_c_req,
  input  wire logic [ADDR_W-1:0]              port_c_addr,
  input  wire logic                           port_c_write,
  input  wire logic [DATA_W-1:0]              port_c_wdata,
  output logic                                present_ack_cpu_port,
  output logic                                port_c_done,
  output logic      [DATA_W-1:0]              port_c_rdata,
  output logic                                override_a_and_b
);
  localparam int MEM_WORDS = MEM_K * WORDS_PER_K;

  // Elaboration check on bank size and cycle length
  if (MEM_K < 4 || MEM_K > 16 || (MEM_K % 4) != 0) begin : g_bad_size
    $error("MEM_K must be 4, 8, 12 or 16");
  end
  if (ACCESS_CYCLES < 1 || ACCESS_CYCLES > 255) begin : g_bad_cyc
    $error("ACCESS_CYCLES must be 1..255");
  end

  // Interleave bit exchange per bank and group size
  function automatic logic [ADDR_W-1:0] il_xform(input logic [ADDR_W-1:0] a,
                                                 input logic [1:0] sz,
                                                 input logic [3:0] il);
    logic [ADDR_W-1:0] t;
    t = a;
    case ({il, sz})
      {IL_8K, SZ_4K}: begin
        t[B19] = a[B31];
        t[B31] = a[B19];
      end
      {IL_16K, SZ_4K}: begin
        t[B19] = a[B30];
        t[B30] = a[B19];
        t[B18] = a[B31];
        t[B31] = a[B18];
      end
      {IL_16K, SZ_8K}: begin
        t[B18] = a[B31];
        t[B31] = a[B18];
      end
      {IL_32K, SZ_4K}, {IL_32K, SZ_8K}: begin
        t[B17] = a[B31];
        t[B31] = a[B17];
        t[B18] = a[B30];
        t[B30] = a[B18];
      end
      {IL_32K, SZ_16K}: begin
        t[B17] = a[B31];
        t[B31] = a[B17];
      end
      {IL_64K, SZ_16K}: begin
        t[B17] = a[B30];
        t[B30] = a[B17];
        t[B16] = a[B31];
        t[B31] = a[B16];
      end
      default: t = a;
    endcase
    return t;
  endfunction : il_xform

  // Start address match on the top five bits
  function automatic logic top_match(input logic [FIELD5_W-1:0] top,
                                     input logic [FIELD5_W-1:0] start,
                                     input logic [1:0] sz);
    case (sz)
      SZ_4K:   return top == start;
      SZ_8K:   return top[4:1] == start[4:1];
      SZ_12K:  return (top[4:2] == start[4:2]) && !(top[1] && top[0]);
      default: return top[4:2] == start[4:2];
    endcase
  endfunction : top_match

  // Register file
  logic [31:0]       cfg_r;
  logic [31:0]       start_r;
  logic [31:0]       expmod_r;
  logic              resp_r;
  logic              perr_r;
  logic [31:0]       avs_readdata_r;
  logic              wr_hit;
  logic [31:0]       wmask;
  logic [1:0]        bank_size;
  logic [3:0]        il_size;
  logic              il_active;
  logic              exp_en;

  // Bank state
  mcba_state_e       state_r;
  logic [7:0]        cnt_r;
  logic [1:0]        grant_r;
  logic [1:0]        exp_sel_r;
  logic [OFF_W-1:0]  hold_addr_r;
  logic [DATA_W-1:0] hold_data_r;
  logic              hold_wr_r;
  logic              port_done_a;
  logic [WORD_W-1:0] mem [MEM_WORDS];

  // Per-port views
  logic [NPORT-1:0]              p_req;
  logic [NPORT-1:0]              p_wr;
  logic [NPORT-1:0][ADDR_W-1:0]  p_addr;
  logic [NPORT-1:0][DATA_W-1:0]  p_wdata;
  logic [NPORT-1:0][ADDR_W-1:0]  p_xaddr;
  logic [NPORT-1:0]              p_hit;
  logic [NEXP-1:0][ADDR_W-1:0]   e_addr;
  logic [NEXP-1:0][ADDR_W-1:0]   e_xaddr;
  logic [NEXP-1:0]               e_req;
  logic [1:0]                    exp_sel;

  assign bank_size = cfg_r[CFG_SIZE_LSB +: 2];
  assign il_size   = cfg_r[CFG_IL_LSB +: 4];
  assign exp_en    = cfg_r[CFG_EXP_BIT];

  // Interleave only with a valid setting and inhibit clear
  always_comb begin
    case ({il_size, bank_size})
      {IL_8K, SZ_4K}, {IL_16K, SZ_4K}, {IL_16K, SZ_8K}, {IL_32K, SZ_4K},
      {IL_32K, SZ_8K}, {IL_32K, SZ_16K}, {IL_64K, SZ_16K}:
        il_active = !cfg_r[CFG_INH_BIT];
      default: il_active = 1'b0;
    endcase
  end

  // Expander inputs with own top-bit offset, input 0 alone when off
  genvar gi;
  for (gi = 0; gi < NEXP; gi++) begin : g_exp
    assign e_req[gi] = exp_req[gi] && (exp_en || gi == 0);
    assign e_addr[gi] = {FIELD5_W'(exp_addr[gi][ADDR_W-1:TOP_LSB]
                                   + expmod_r[gi*START_STEP +: FIELD5_W]),
                         exp_addr[gi][TOP_LSB-1:0]};
    assign e_xaddr[gi] = il_active ? il_xform(e_addr[gi], bank_size, il_size)
                                   : e_addr[gi];
    assign exp_present[gi] = e_req[gi] && top_match(
      e_xaddr[gi][ADDR_W-1:TOP_LSB],
      start_r[PORT_A*START_STEP +: FIELD5_W], bank_size);
    assign exp_done[gi] = port_done_a && exp_sel_r == 2'(gi);
  end

  // Highest-numbered requesting expander input wins
  always_comb begin
    exp_sel = 2'd0;
    for (int i = 0; i < NEXP; i++) begin
      if (e_req[i]) begin
        exp_sel = 2'(i);
      end
    end
  end

  // Gather the three ports
  assign p_req   = {port_c_req, port_b_req, |e_req};
  assign p_wr    = {port_c_write, port_b_write, exp_write[exp_sel]};
  assign p_addr  = {port_c_addr, port_b_addr, e_addr[exp_sel]};
  assign p_wdata = {port_c_wdata, port_b_wdata, exp_wdata[exp_sel]};

  // Transform and compare against each port's own start
  for (gi = 0; gi < NPORT; gi++) begin : g_port
    assign p_xaddr[gi] = il_active ? il_xform(p_addr[gi], bank_size, il_size)
                                   : p_addr[gi];
    assign p_hit[gi] = p_req[gi] && top_match(
      p_xaddr[gi][ADDR_W-1:TOP_LSB],
      start_r[gi*START_STEP +: FIELD5_W], bank_size);
  end

  assign present_ack_first_port = p_hit[PORT_A];
  assign present_ack_b          = p_hit[PORT_B];
  assign present_ack_cpu_port   = p_hit[PORT_C];

  // Bank access sequencer; only this bank's ports compete
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_r   <= MCBA_IDLE;
      cnt_r     <= 8'h00;
      grant_r   <= PORT_A;
      exp_sel_r <= 2'd0;
      hold_wr_r <= 1'b0;
    end else begin
      case (state_r)
        MCBA_IDLE: begin
          if (|p_hit) begin
            state_r   <= MCBA_CYCLE;
            cnt_r     <= 8'(ACCESS_CYCLES - 1);
            exp_sel_r <= exp_sel;
            if (p_hit[PORT_A]) begin
              grant_r   <= PORT_A;
              hold_wr_r <= p_wr[PORT_A];
            end else if (p_hit[PORT_B]) begin
              grant_r   <= PORT_B;
              hold_wr_r <= p_wr[PORT_B];
            end else begin
              grant_r   <= PORT_C;
              hold_wr_r <= p_wr[PORT_C];
            end
          end
        end
        MCBA_CYCLE: begin
          if (cnt_r == 8'h00) begin
            state_r <= MCBA_DONE;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        MCBA_DONE: state_r <= MCBA_IDLE;
        default:   state_r <= MCBA_IDLE;
      endcase
    end
  end

  // Address holding register, offset within the bank
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hold_addr_r <= '0;
    end else if (state_r == MCBA_IDLE && |p_hit) begin
      hold_addr_r <= p_hit[PORT_A] ? p_xaddr[PORT_A][OFF_W-1:0]
                   : p_hit[PORT_B] ? p_xaddr[PORT_B][OFF_W-1:0]
                   : p_xaddr[PORT_C][OFF_W-1:0];
    end
  end

  // Word index masked to the bank size
  logic [OFF_W-1:0] mem_idx;
  always_comb begin
    case (bank_size)
      SZ_4K:   mem_idx = {2'b00, hold_addr_r[OFF_W-3:0]};
      SZ_8K:   mem_idx = {1'b0, hold_addr_r[OFF_W-2:0]};
      default: mem_idx = hold_addr_r;
    endcase
  end
  wire mem_ok  = 32'(mem_idx) < MEM_WORDS;
  wire cyc_end = state_r == MCBA_CYCLE && cnt_r == 8'h00;

  // Data holding register: write data in, read data back out
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hold_data_r <= '0;
    end else if (state_r == MCBA_IDLE && |p_hit) begin
      hold_data_r <= p_hit[PORT_A] ? p_wdata[PORT_A]
                   : p_hit[PORT_B] ? p_wdata[PORT_B]
                   : p_wdata[PORT_C];
    end else if (cyc_end && !hold_wr_r) begin
      hold_data_r <= mem_ok ? mem[mem_idx][DATA_W-1:0] : '0;
    end
  end

  // Core store with generated odd parity
  always_ff @(posedge clk_sys) begin
    if (cyc_end && hold_wr_r && mem_ok) begin
      mem[mem_idx] <= {~^hold_data_r, hold_data_r};
    end
  end

  // Parity check on read, sticky; set wins over clear
  wire perr_set = cyc_end && !hold_wr_r && mem_ok && !(^mem[mem_idx]);
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      perr_r <= 1'b0;
    end else if (perr_set) begin
      perr_r <= 1'b1;
    end else if (wr_hit && avs_address == REG_STATUS && avs_byteenable[0]
                 && avs_writedata[ST_PERR]) begin
      perr_r <= 1'b0;
    end
  end

  // Completion pulses, owner overrides and returned data
  wire owned       = state_r != MCBA_IDLE;
  assign port_done_a = state_r == MCBA_DONE && grant_r == PORT_A;
  assign port_b_done = state_r == MCBA_DONE && grant_r == PORT_B;
  assign port_c_done = state_r == MCBA_DONE && grant_r == PORT_C;
  assign override_b_and_c_to_a = owned && grant_r == PORT_A;
  assign override_a_and_c      = owned && grant_r == PORT_B;
  assign override_a_and_b      = owned && grant_r == PORT_C;
  assign exp_rdata    = hold_data_r;
  assign port_b_rdata = hold_data_r;
  assign port_c_rdata = hold_data_r;

  // Avalon slave: one wait cycle, then the answer
  assign avs_waitrequest = (avs_read || avs_write) && !resp_r;
  assign wr_hit = avs_write && resp_r;
  assign avs_readdata = avs_readdata_r;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{avs_byteenable[i]}};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      resp_r <= 1'b0;
    end else begin
      resp_r <= (avs_read || avs_write) && !resp_r;
    end
  end

  // Configuration registers with byte enables
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cfg_r    <= CFG_RST;
      start_r  <= START_RST;
      expmod_r <= EXPMOD_RST;
    end else if (wr_hit) begin
      case (avs_address)
        REG_CFG:    cfg_r    <= (cfg_r & ~wmask) | (avs_writedata & wmask);
        REG_START:  start_r  <= (start_r & ~wmask) | (avs_writedata & wmask);
        REG_EXPMOD: expmod_r <= (expmod_r & ~wmask) | (avs_writedata & wmask);
        default:    ;
      endcase
    end
  end

  // Read data, zero for unmapped and unused bits
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      avs_readdata_r <= 32'h0000_0000;
    end else if (avs_read && !resp_r) begin
      case (avs_address)
        REG_CFG:    avs_readdata_r <= cfg_r & 32'h0000_07FF;
        REG_START:  avs_readdata_r <= start_r & 32'h001F_1F1F;
        REG_EXPMOD: avs_readdata_r <= expmod_r & 32'h1F1F_1F1F;
        REG_STATUS: begin
          avs_readdata_r <= 32'h0000_0000;
          avs_readdata_r[ST_BUSY]          <= owned;
          avs_readdata_r[ST_GRANT +: 2]    <= grant_r;
          avs_readdata_r[ST_IL_ACT]        <= il_active;
          avs_readdata_r[ST_PERR]          <= perr_r;
          avs_readdata_r[ST_BANK_LSB +: 3] <= cfg_r[CFG_BANK_LSB +: 3];
        end
        default:    avs_readdata_r <= 32'h0000_0000;
      endcase
    end
  end
endmodule : mcba_bank

// file: rtl/mcba_pkg.sv
// Constants and types for the multiport core bank access block
package mcba_pkg;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 32;
  localparam int WORD_W = 33;
  localparam int NPORT  = 3;
  localparam int NEXP   = 4;
  localparam int OFF_W  = 14;
  localparam int WORDS_PER_K = 1024;

  // Port indexes, highest priority first
  localparam logic [1:0] PORT_A = 2'h0;
  localparam logic [1:0] PORT_B = 2'h1;
  localparam logic [1:0] PORT_C = 2'h2;

  // Register byte offsets on the Avalon slave
  localparam logic [3:0] REG_CFG    = 4'h0;
  localparam logic [3:0] REG_START  = 4'h4;
  localparam logic [3:0] REG_EXPMOD = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'hC;

  // Configuration fields
  localparam int CFG_SIZE_LSB = 0;
  localparam int CFG_IL_LSB   = 2;
  localparam int CFG_BANK_LSB = 6;
  localparam int CFG_INH_BIT  = 9;
  localparam int CFG_EXP_BIT  = 10;
  localparam int START_STEP   = 8;
  localparam int FIELD5_W     = 5;
  localparam logic [31:0] CFG_RST    = 32'h0000_0003;
  localparam logic [31:0] START_RST  = 32'h0000_0000;
  localparam logic [31:0] EXPMOD_RST = 32'h0000_0000;

  // Status fields
  localparam int ST_BUSY     = 0;
  localparam int ST_GRANT    = 1;
  localparam int ST_IL_ACT   = 3;
  localparam int ST_PERR     = 4;
  localparam int ST_BANK_LSB = 8;

  // Bank size and interleave size codes
  localparam logic [1:0] SZ_4K  = 2'b00;
  localparam logic [1:0] SZ_8K  = 2'b01;
  localparam logic [1:0] SZ_12K = 2'b10;
  localparam logic [1:0] SZ_16K = 2'b11;
  localparam logic [3:0] IL_8K  = 4'b0001;
  localparam logic [3:0] IL_16K = 4'b0010;
  localparam logic [3:0] IL_32K = 4'b0100;
  localparam logic [3:0] IL_64K = 4'b1000;

  // Positions of address bits 16..19, 30, 31 in a 17-bit word address
  localparam int B16 = 15;
  localparam int B17 = 14;
  localparam int B18 = 13;
  localparam int B19 = 12;
  localparam int B30 = 1;
  localparam int B31 = 0;
  localparam int TOP_LSB = 12;

  typedef enum logic [1:0] {MCBA_IDLE, MCBA_CYCLE, MCBA_DONE} mcba_state_e;
endpackage : mcba_pkg

// file: verif/mcba_requester.sv
// Behavioural requester standing in for a CPU or IOP at one bank port
`timescale 1ns/1ps
module mcba_requester
  import mcba_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic              go,
  input  wire logic              abort,
  input  wire logic              cmd_write,
  input  wire logic [ADDR_W-1:0] cmd_addr,
  input  wire logic [DATA_W-1:0] cmd_wdata,
  input  wire logic              done,
  input  wire logic [DATA_W-1:0] rdata,
  output logic                   req_r,
  output logic                   write_r,
  output logic      [ADDR_W-1:0] addr_r,
  output logic      [DATA_W-1:0] wdata_r,
  output logic      [DATA_W-1:0] got_r
);
  // Hold a request until served or aborted; released address and data lines are inverted, write_r keeps its value
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      req_r   <= 1'b0;
      write_r <= 1'b0;
      addr_r  <= '0;
      wdata_r <= '0;
      got_r   <= '0;
    end else if (go) begin
      req_r   <= 1'b1;
      write_r <= cmd_write;
      addr_r  <= cmd_addr;
      wdata_r <= cmd_wdata;
    end else begin
      if (req_r && done) got_r <= rdata;
      if (!req_r || done || abort) begin
        req_r   <= 1'b0;
        addr_r  <= ~addr_r;
        wdata_r <= ~wdata_r;
      end
    end
  end
endmodule : mcba_requester

// file: verif/mcba_bank_asserts.sv
// Concurrent checks on the bank's port arbitration outputs
`timescale 1ns/1ps
module mcba_bank_asserts
  import mcba_pkg::*;
#(
  parameter int ACCESS_CYCLES = 4
) (
  input wire logic            clk_sys,
  input wire logic            rst,
  input wire logic [NEXP-1:0] exp_done,
  input wire logic            present_ack_first_port,
  input wire logic            override_b_and_c_to_a,
  input wire logic            present_ack_b,
  input wire logic            port_b_done,
  input wire logic            override_a_and_c,
  input wire logic            port_c_req,
  input wire logic            present_ack_cpu_port,
  input wire logic            port_c_done,
  input wire logic            override_a_and_b
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // Some port owns the bank
  logic own_any;
  assign own_any = override_b_and_c_to_a | override_a_and_c | override_a_and_b;
  lone_owner_a: assert property ($onehot0({override_b_and_c_to_a, override_a_and_c, override_a_and_b}))
    else $error("more than one port owns the bank");
  c_done_owner_a: assert property (port_c_done |-> override_a_and_b)
    else $error("port C done without owning the bank");
  c_latency_a: assert property ($rose(override_a_and_b) |-> ##ACCESS_CYCLES port_c_done)
    else $error("port C cycle length wrong");
  b_over_c_a: assert property (present_ack_b && port_c_req && present_ack_cpu_port && !present_ack_first_port
    && !own_any |=> override_a_and_c) else $error("port B did not win over port C");
  a_over_b_a: assert property (present_ack_first_port && present_ack_b && !own_any && !$past(own_any)
    |=> override_b_and_c_to_a) else $error("port A did not win over port B");
  exp_single_a: assert property ($onehot0(exp_done))
    else $error("two expander inputs served at once");
  b_hold_a: assert property ($rose(override_a_and_c) |-> override_a_and_c[*5] ##1 !override_a_and_c)
    else $error("port B ownership length wrong");
  c_taken_a: assert property ($rose(override_a_and_b) |-> $past(port_c_req) && $past(present_ack_cpu_port))
    else $error("port C granted without a present request");
  b_done_pulse_a: assert property (port_b_done |-> override_a_and_c ##1 !port_b_done)
    else $error("port B done not a single owned pulse");
  cover property ($rose(override_b_and_c_to_a));
  cover property ($rose(override_a_and_c));
  cover property ($rose(override_a_and_b));
  cover property (exp_done[3]);
endmodule : mcba_bank_asserts
bind mcba_bank mcba_bank_asserts #(.ACCESS_CYCLES(ACCESS_CYCLES)) u_asserts (
  .clk_sys(clk_sys), .rst(rst), .exp_done(exp_done), .present_ack_first_port(present_ack_first_port),
  .override_b_and_c_to_a(override_b_and_c_to_a), .present_ack_b(present_ack_b), .port_b_done(port_b_done),
  .override_a_and_c(override_a_and_c), .port_c_req(port_c_req), .present_ack_cpu_port(present_ack_cpu_port),
  .port_c_done(port_c_done), .override_a_and_b(override_a_and_b)
);

// file: verif/mcba_bank_tb.sv
// Self-checking bench for the core bank: register bus and six requesters
`timescale 1ns/1ps
module mcba_bank_tb;
  import mcba_pkg::*;
  localparam int NREQ = 6;
  logic              clk_sys;
  logic              rst;
  logic [3:0]        avs_address;
  logic              avs_read;
  logic              avs_write;
  logic [31:0]       avs_writedata;
  wire  [31:0]       avs_readdata;
  wire               avs_waitrequest;
  logic [NREQ-1:0]   go;
  logic [NREQ-1:0]   abort;
  logic [NREQ-1:0]   cmd_write;
  logic [ADDR_W-1:0] cmd_addr [NREQ];
  logic [DATA_W-1:0] cmd_wdata [NREQ];
  wire  [NREQ-1:0]   req;
  wire  [NREQ-1:0]   wr;
  wire  [NREQ-1:0]   done;
  wire  [NREQ-1:0]   present;
  wire  [ADDR_W-1:0] addr [NREQ];
  wire  [DATA_W-1:0] wdata [NREQ];
  wire  [DATA_W-1:0] got [NREQ];
  wire  [DATA_W-1:0] exp_rdata;
  wire  [DATA_W-1:0] b_rdata;
  wire  [DATA_W-1:0] c_rdata;
  logic [31:0]       rd;
  int                order [$];
  int                miscompares;
  int                comparisons;

  mcba_bank DUT (
    .clk_sys(clk_sys), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .exp_req(req[3:0]),
    .exp_addr({addr[3], addr[2], addr[1], addr[0]}), .exp_write(wr[3:0]),
    .exp_wdata({wdata[3], wdata[2], wdata[1], wdata[0]}), .exp_present(present[3:0]),
    .exp_done(done[3:0]), .exp_rdata(exp_rdata), .present_ack_first_port(),
    .override_b_and_c_to_a(), .port_b_req(req[4]), .port_b_addr(addr[4]), .port_b_write(wr[4]),
    .port_b_wdata(wdata[4]), .present_ack_b(present[4]), .port_b_done(done[4]),
    .port_b_rdata(b_rdata), .override_a_and_c(), .port_c_req(req[5]), .port_c_addr(addr[5]),
    .port_c_write(wr[5]), .port_c_wdata(wdata[5]), .present_ack_cpu_port(present[5]),
    .port_c_done(done[5]), .port_c_rdata(c_rdata), .override_a_and_b()
  );

  // Requesters 0..3 on the expander, 4 on port B, 5 on port C
  for (genvar i = 0; i < NREQ; i++) begin : g_req
    mcba_requester u_req (
      .clk_sys(clk_sys), .rst(rst), .go(go[i]), .abort(abort[i]), .cmd_write(cmd_write[i]),
      .cmd_addr(cmd_addr[i]), .cmd_wdata(cmd_wdata[i]), .done(done[i]),
      .rdata(i < NEXP ? exp_rdata : (i == 4 ? b_rdata : c_rdata)), .req_r(req[i]),
      .write_r(wr[i]), .addr_r(addr[i]), .wdata_r(wdata[i]), .got_r(got[i])
    );
  end

  // 200 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // Record the order in which requesters are served
  always @(posedge clk_sys) begin
    for (int i = 0; i < NREQ; i++) begin
      if (done[i] === 1'b1) order.push_back(i);
    end
  end

  task automatic close_out();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out

  task automatic hang();
    miscompares++;
    close_out();
  endtask : hang

  task automatic chk(input logic [31:0] got_v, input logic [31:0] exp_v);
    comparisons++;
    if (got_v !== exp_v) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got_v, exp_v);
    end
  endtask : chk

  function automatic logic [31:0] order_word();
    logic [31:0] pk;
    pk = 32'h0000_0000;
    foreach (order[k]) pk = {pk[27:0], order[k][3:0]};
    return pk;
  endfunction : order_word

  // One Avalon access; read data taken at the edge that ends the wait
  task automatic bus(input logic rnw, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= rnw;
    avs_write     <= !rnw;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_sys);
      if (avs_waitrequest === 1'b0) break;
    end
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (n == 50) hang();
  endtask : bus

  task automatic launch(input logic [NREQ-1:0] m, input logic w, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d);
    @(posedge clk_sys);
    for (int i = 0; i < NREQ; i++) begin
      cmd_write[i] <= m[i] ? w : cmd_write[i];
      cmd_addr[i]  <= m[i] ? a : cmd_addr[i];
      cmd_wdata[i] <= m[i] ? d : cmd_wdata[i];
    end
    go <= m;
    @(posedge clk_sys);
    go <= '0;
  endtask : launch

  task automatic settle(input logic [NREQ-1:0] m);
    int n;
    for (n = 0; n < 200; n++) begin
      @(negedge clk_sys);
      if ((req & m) === '0) break;
    end
    if (n == 200) hang();
  endtask : settle

  task automatic access(input int i, input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    launch(NREQ'(1 << i), w, a, d);
    settle(NREQ'(1 << i));
  endtask : access

  // Request a read and check the present acknowledge; withdraw on a miss
  task automatic probe(input int i, input logic [ADDR_W-1:0] a, input logic hit);
    launch(NREQ'(1 << i), 1'b0, a, 32'h0000_0000);
    @(negedge clk_sys);
    chk(present[i], hit);
    if (hit !== 1'b1) begin
      @(posedge clk_sys);
      abort[i] <= 1'b1;
      @(posedge clk_sys);
      abort[i] <= 1'b0;
    end
    settle(NREQ'(1 << i));
  endtask : probe

  // Cut a hung run short
  initial begin
    repeat (50000) @(posedge clk_sys);
    hang();
  end

  // Main sequence
  initial begin
    miscompares = 0;
    comparisons = 0;
    rst = 1'b1;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    go = '0;
    abort = '0;
    cmd_write = '0;
    foreach (cmd_addr[i]) cmd_addr[i] = '0;
    foreach (cmd_wdata[i]) cmd_wdata[i] = '0;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    bus(1'b1, REG_CFG, 32'h0000_0000);
    chk(rd, CFG_RST);
    bus(1'b1, REG_START, 32'h0000_0000);
    chk(rd, START_RST);
    bus(1'b0, 4'h2, 32'hFFFF_FFFF);
    bus(1'b1, 4'h2, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    $display("test registers done");
    access(5, 1'b1, 17'h0_0123, 32'hA5A5_0F0F);
    access(4, 1'b1, 17'h0_0124, 32'h5A5A_F0F0);
    access(0, 1'b1, 17'h0_3FFF, 32'h8000_0001);
    access(5, 1'b0, 17'h0_0124, 32'h0000_0000);
    chk(got[5], 32'h5A5A_F0F0);
    access(4, 1'b0, 17'h0_0123, 32'h0000_0000);
    chk(got[4], 32'hA5A5_0F0F);
    access(5, 1'b0, 17'h0_3FFF, 32'h0000_0000);
    chk(got[5], 32'h8000_0001);
    bus(1'b1, REG_STATUS, 32'h0000_0000);
    chk(rd[ST_PERR], 32'h0000_0000);
    $display("test data path done");
    order.delete();
    launch(6'h31, 1'b0, 17'h0_0123, 32'h0000_0000);
    settle(6'h31);
    chk(order_word(), 32'h0000_0045);
    chk(got[5], 32'hA5A5_0F0F);
    $display("test port priority done");
    bus(1'b0, REG_CFG, CFG_RST | (32'h0000_0001 << CFG_EXP_BIT));
    order.delete();
    launch(6'h0F, 1'b0, 17'h0_0124, 32'h0000_0000);
    settle(6'h0F);
    chk(order_word(), 32'h0000_3210);
    bus(1'b0, REG_EXPMOD, 32'h0004_0100);
    access(5, 1'b1, 17'h0_1005, 32'h1357_9BDF);
    access(1, 1'b0, 17'h0_0005, 32'h0000_0000);
    chk(got[1], 32'h1357_9BDF);
    probe(2, 17'h0_0000, 1'b0);
    probe(3, 17'h0_0000, 1'b1);
    $display("test expander done");
    bus(1'b0, REG_EXPMOD, EXPMOD_RST);
    bus(1'b0, REG_START, 32'h0004_0000);
    access(4, 1'b1, 17'h0_0007, 32'h2468_ACE0);
    access(5, 1'b0, 17'h0_4007, 32'h0000_0000);
    chk(got[5], 32'h2468_ACE0);
    probe(5, 17'h0_0007, 1'b0);
    bus(1'b0, REG_START, START_RST);
    bus(1'b0, REG_CFG, {30'h0000_0000, SZ_12K});
    probe(5, 17'h0_3000, 1'b0);
    probe(5, 17'h0_2FFF, 1'b1);
    $display("test start address done");
    bus(1'b0, REG_CFG, {26'h000_0000, IL_8K, SZ_4K});
    bus(1'b1, REG_STATUS, 32'h0000_0000);
    chk(rd[ST_IL_ACT], 32'h0000_0001);
    probe(5, 17'h0_0000, 1'b1);
    probe(5, 17'h0_0001, 1'b0);
    probe(4, 17'h0_0003, 1'b0);
    probe(4, 17'h0_0002, 1'b1);
    bus(1'b0, REG_CFG, {22'h00_0000, 1'b1, 3'h0, IL_8K, SZ_4K});
    bus(1'b1, REG_STATUS, 32'h0000_0000);
    chk(rd[ST_IL_ACT], 32'h0000_0000);
    probe(5, 17'h0_0001, 1'b1);
    $display("test interleave done");
    close_out();
  end
endmodule : mcba_bank_tb
